/* File: src/lcd_pkg.sv */
// package: command codes, field layouts, reset values for the lcd decoder
package lcd_pkg;
  localparam logic [7:0] LCD_CMD_DISP_OFF = 8'hAE;
  localparam logic [6:0] LCD_PFX_DISP = 7'b1010111;
  localparam logic [6:0] LCD_PFX_REVERSE = 7'b1010011;
  localparam logic [6:0] LCD_PFX_ALLON = 7'b1010010;
  localparam logic [6:0] LCD_PFX_SEGDIR = 7'b1010000;
  localparam logic [4:0] LCD_PFX_COMDIR = 5'b11000;
  localparam logic [3:0] LCD_PFX_PAGE = 4'b1011;
  localparam logic [3:0] LCD_PFX_COL_HI = 4'b0001;
  localparam logic [3:0] LCD_PFX_COL_LO = 4'b0000;
  localparam logic [1:0] LCD_PFX_START = 2'b01;
  localparam logic [4:0] LCD_PFX_POWER = 5'b00101;
  localparam logic [4:0] LCD_PFX_RATIO = 5'b00100;
  localparam logic [2:0] LCD_PFX_VOLUME = 3'b100;
  localparam logic [6:0] LCD_PFX_BIAS = 7'b1010001;
  localparam logic [7:0] LCD_CMD_RMW = 8'hE0;
  localparam logic [7:0] LCD_CMD_END = 8'hEE;
  localparam logic [7:0] LCD_CMD_RESET = 8'hE2;
  localparam logic [3:0] LCD_PAGE_LAST = 4'h8;
  localparam logic [7:0] LCD_COL_LAST = 8'h83;
  localparam logic [4:0] LCD_VOLUME_RST = 5'h10;
  localparam int LCD_COL_W = 8;
  localparam int LCD_PAGE_W = 4;
  localparam int LCD_MEM_DEPTH = 9 * 132;
  localparam int LCD_ADDR_W = 11;

  typedef struct packed {
    logic disp_on;
    logic reverse;
    logic all_on;
    logic seg_rev;
    logic com_rev;
    logic rmw;
    logic [2:0] power_ctl;
    logic [2:0] ratio;
    logic [4:0] volume;
    logic bias_7;
    logic test_mode;
    logic [5:0] start_line;
    logic [3:0] page;
    logic [7:0] col;
    logic [7:0] rmw_col;
  } lcd_cfg_s;

  typedef struct packed {
    logic [7:0] data;
    logic is_data;
    logic is_read;
    logic valid;
  } lcd_xfer_s;
endpackage

/* File: src/lcd_mem.sv */
// display memory: one byte per page/column, registered read data
`timescale 1ns/1ns
module lcd_mem
  import lcd_pkg::*;
#(
  parameter int DEPTH = LCD_MEM_DEPTH,
  parameter int AW = LCD_ADDR_W
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [7:0] wr_mask,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  // no reset on the array: contents survive every reset source
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= (mem[addr] & ~wr_mask) | (wr_data & wr_mask);
    end
    rd_data <= mem[addr];
  end
endmodule // lcd_mem

/* File: src/lcd_command_decoder.sv */
// lcd command decoder: host bus front end, command decode, reset state
// Summary of operation
// - reset pin low or reset command initializes
// - reset clears serial shift register and counter
// - reset enters power saver, outputs grounded
// - reset sets addresses, directions, polarity to defaults
// - reset clears power control and ratio
// - reset loads volume 10000, bias 1/7, no test
// - reset leaves display memory untouched
// - 8080 mode acts on low read/write pulses
// - 6800 mode uses rw level and enable pulse
// - serial bytes arrive most significant bit first
// - 1010111x turns display off or on
// - display off plus all on gives power saver
// - 1010011x selects normal or reverse polarity
// - 1010010x forces all pixels on when set
// - 1011xxxx loads page address, pages 0 to 8
// - page steps after last column, wraps after 8
// - indicator page writes change only bit 0
// - column address loaded as two nibble commands
// - column steps per access except reads in read-modify-write, wraps after 83h
// - 01xxxxxx loads display start line
// - 1010000x selects segment direction
`timescale 1ns/1ns
module lcd_command_decoder
  import lcd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hardware_clear_n,
  input wire logic mode_6800,
  input wire logic serial_sel,
  input wire logic chip_sel_n,
  input wire logic cmd_data_select,
  input wire logic rd_e,
  input wire logic wr_rw,
  input wire logic [7:0] bus_in,
  input wire logic ser_clk,
  input wire logic ser_data,
  output logic [7:0] bus_out,
  output logic bus_oe,
  output logic power_saver,
  output logic osc_enable,
  output logic lcd_supply_enable,
  output logic drivers_grounded,
  output logic display_on,
  output logic all_points_on,
  output logic reverse_polarity,
  output logic seg_reverse,
  output logic com_reverse,
  output logic [5:0] start_line,
  output logic [3:0] page_addr,
  output logic [7:0] column_addr,
  output logic [2:0] power_control,
  output logic [2:0] ratio_select,
  output logic [4:0] volume,
  output logic bias_sel_7,
  output logic test_mode
);
  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] cs_sync;
    logic [1:0] a0_sync;
    logic [1:0] rd_sync;
    logic [1:0] wr_sync;
    logic [1:0] sck_sync;
    logic [1:0] sdi_sync;
    logic [15:0] bus_sync;
    logic rd_prev;
    logic wr_prev;
    logic sck_prev;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic rd_pend;
    logic [7:0] bus_out;
    logic bus_oe;
    lcd_cfg_s cfg;
  } lcd_state_s;

  lcd_state_s s_q, s_d;
  lcd_xfer_s xfer;
  logic [7:0] mem_rd;
  logic mem_we;
  logic [7:0] mem_mask;
  logic [7:0] mem_wdata;
  logic [LCD_ADDR_W-1:0] mem_addr;
  logic soft_reset;

  function automatic lcd_cfg_s cfg_reset();
    lcd_cfg_s c;
    c = '0;
    c.all_on = 1'b1;
    c.disp_on = 1'b0;
    c.volume = LCD_VOLUME_RST;
    c.bias_7 = 1'b1;
    return c;
  endfunction

  // advance page/column after one display memory access
  function automatic lcd_cfg_s step_addr(input lcd_cfg_s c);
    lcd_cfg_s r;
    r = c;
    if (c.col == LCD_COL_LAST) begin
      r.col = '0;
      if (c.page == LCD_PAGE_LAST) begin
        r.page = '0;
      end else begin
        r.page = c.page + 4'h1;
      end
    end else begin
      r.col = c.col + 8'h01;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // strobe and serial decode
  logic rd_act, wr_act, rd_fall, rd_rise, wr_rise, sck_rise, cs_ok;

  always_comb begin
    cs_ok = ~s_q.cs_sync[1];
    // 8080: low pulses act, 6800: high enable pulse with rw level
    rd_act = mode_6800 ? (s_q.rd_sync[1] & s_q.wr_sync[1])
                       : ~s_q.rd_sync[1];
    wr_act = mode_6800 ? (s_q.rd_sync[1] & ~s_q.wr_sync[1])
                       : ~s_q.wr_sync[1];
    rd_fall = rd_act & ~s_q.rd_prev;
    rd_rise = ~rd_act & s_q.rd_prev;
    wr_rise = ~wr_act & s_q.wr_prev;
    sck_rise = s_q.sck_sync[1] & ~s_q.sck_prev;
    xfer = '0;
    xfer.is_data = s_q.a0_sync[1];
    if (serial_sel) begin
      xfer.data = {s_q.shift[6:0], s_q.sdi_sync[1]};
      xfer.valid = cs_ok & sck_rise & (s_q.bit_cnt == 3'd7);
    end else begin
      xfer.data = s_q.bus_sync[15:8];
      xfer.valid = cs_ok & wr_rise; // write latched at trailing edge
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    soft_reset = 1'b0;
    mem_we = 1'b0;
    mem_mask = 8'hFF;
    mem_wdata = xfer.data;
    s_d.rst_sync = {s_q.rst_sync[0], hardware_clear_n};
    s_d.cs_sync = {s_q.cs_sync[0], chip_sel_n};
    s_d.a0_sync = {s_q.a0_sync[0], cmd_data_select};
    s_d.rd_sync = {s_q.rd_sync[0], rd_e};
    s_d.wr_sync = {s_q.wr_sync[0], wr_rw};
    s_d.sck_sync = {s_q.sck_sync[0], ser_clk};
    s_d.sdi_sync = {s_q.sdi_sync[0], ser_data};
    s_d.bus_sync = {s_q.bus_sync[7:0], bus_in};
    s_d.rd_prev = rd_act & ~serial_sel;
    s_d.wr_prev = wr_act & ~serial_sel;
    s_d.sck_prev = s_q.sck_sync[1];
    s_d.rd_pend = 1'b0;

    if (serial_sel && cs_ok && sck_rise) begin
      s_d.shift = xfer.data;
      s_d.bit_cnt = s_q.bit_cnt + 3'd1;
    end

    // parallel read: drive registered data while strobe active
    if (!serial_sel && cs_ok && rd_fall) begin
      s_d.rd_pend = 1'b1;
    end
    if (s_q.rd_pend) begin
      s_d.bus_out = mem_rd;
      s_d.bus_oe = 1'b1;
    end
    if (rd_rise || !cs_ok || serial_sel) begin
      s_d.bus_oe = 1'b0;
      // a strobe seen while deselected (mode switch) must not step
      if (rd_rise && cs_ok && s_q.a0_sync[1] && !s_q.cfg.rmw) begin
        s_d.cfg = step_addr(s_q.cfg);
      end
    end

    if (xfer.valid && xfer.is_data) begin
      mem_we = 1'b1;
      if (s_q.cfg.page == LCD_PAGE_LAST) begin
        mem_mask = 8'h01;
      end
      s_d.cfg = step_addr(s_q.cfg);
    end else if (xfer.valid) begin
      if (xfer.data[7:1] == LCD_PFX_DISP) begin
        s_d.cfg.disp_on = xfer.data[0];
      end else if (xfer.data[7:1] == LCD_PFX_REVERSE) begin
        s_d.cfg.reverse = xfer.data[0];
      end else if (xfer.data[7:1] == LCD_PFX_ALLON) begin
        s_d.cfg.all_on = xfer.data[0];
      end else if (xfer.data[7:1] == LCD_PFX_SEGDIR) begin
        s_d.cfg.seg_rev = xfer.data[0];
      end else if (xfer.data[7:1] == LCD_PFX_BIAS) begin
        s_d.cfg.bias_7 = xfer.data[0];
      end else if (xfer.data[7:3] == LCD_PFX_COMDIR) begin
        s_d.cfg.com_rev = xfer.data[3];
      end else if (xfer.data[7:4] == LCD_PFX_PAGE) begin
        s_d.cfg.page = xfer.data[3:0];
      end else if (xfer.data[7:4] == LCD_PFX_COL_HI) begin
        s_d.cfg.col[7:4] = xfer.data[3:0];
      end else if (xfer.data[7:4] == LCD_PFX_COL_LO) begin
        s_d.cfg.col[3:0] = xfer.data[3:0];
      end else if (xfer.data[7:6] == LCD_PFX_START) begin
        s_d.cfg.start_line = xfer.data[5:0];
      end else if (xfer.data[7:3] == LCD_PFX_POWER) begin
        s_d.cfg.power_ctl = xfer.data[2:0];
      end else if (xfer.data[7:3] == LCD_PFX_RATIO) begin
        s_d.cfg.ratio = xfer.data[2:0];
      end else if (xfer.data[7:5] == LCD_PFX_VOLUME) begin
        s_d.cfg.volume = xfer.data[4:0];
      end else if (xfer.data == LCD_CMD_RMW) begin
        s_d.cfg.rmw = 1'b1;
        s_d.cfg.rmw_col = s_q.cfg.col;
      end else if (xfer.data == LCD_CMD_END) begin
        s_d.cfg.rmw = 1'b0;
        s_d.cfg.col = s_q.cfg.rmw_col;
      end else if (xfer.data == LCD_CMD_RESET) begin
        soft_reset = 1'b1;
      end
    end

    // pin reset (synchronised) and reset command act alike
    if (soft_reset || !s_q.rst_sync[1]) begin
      s_d.cfg = cfg_reset();
      s_d.shift = '0;
      s_d.bit_cnt = '0;
      s_d.bus_oe = 1'b0;
    end
    // chip deselect realigns the serial byte boundary
    if (!cs_ok) begin
      s_d.bit_cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.rst_sync <= 2'b00;
      s_q.cs_sync <= 2'b11;
      s_q.cfg.all_on <= 1'b1;
      s_q.cfg.volume <= LCD_VOLUME_RST;
      s_q.cfg.bias_7 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display memory, not touched by reset
  assign mem_addr = LCD_ADDR_W'(s_q.cfg.page * 132 + s_q.cfg.col);

  lcd_mem #(
    .DEPTH(LCD_MEM_DEPTH),
    .AW(LCD_ADDR_W)
  ) u_mem (
    .clk(clk),
    .wr_en(mem_we),
    .wr_mask(mem_mask),
    .addr(mem_addr),
    .wr_data(mem_wdata),
    .rd_data(mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    power_saver = ~s_q.cfg.disp_on & s_q.cfg.all_on;
    osc_enable = ~power_saver;
    lcd_supply_enable = ~power_saver;
    drivers_grounded = power_saver;
    display_on = s_q.cfg.disp_on;
    all_points_on = s_q.cfg.all_on;
    reverse_polarity = s_q.cfg.reverse & ~s_q.cfg.all_on;
    seg_reverse = s_q.cfg.seg_rev;
    com_reverse = s_q.cfg.com_rev;
    start_line = s_q.cfg.start_line;
    page_addr = s_q.cfg.page;
    column_addr = s_q.cfg.col;
    power_control = s_q.cfg.power_ctl;
    ratio_select = s_q.cfg.ratio;
    volume = s_q.cfg.volume;
    bias_sel_7 = s_q.cfg.bias_7;
    test_mode = s_q.cfg.test_mode;
    bus_out = s_q.bus_out;
    bus_oe = s_q.bus_oe;
  end
endmodule // lcd_command_decoder

/* File: testbench/lcd_command_decoder_asserts.sv */
// checker: output relations of the lcd command decoder
`timescale 1ns/1ns
module lcd_command_decoder_asserts
  import lcd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hardware_clear_n,
  input wire logic chip_sel_n,
  input wire logic bus_oe,
  input wire logic power_saver,
  input wire logic osc_enable,
  input wire logic lcd_supply_enable,
  input wire logic drivers_grounded,
  input wire logic display_on,
  input wire logic all_points_on,
  input wire logic reverse_polarity,
  input wire logic [5:0] start_line,
  input wire logic [3:0] page_addr,
  input wire logic [7:0] column_addr,
  input wire logic [4:0] volume,
  input wire logic bias_sel_7
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  // four low samples clear the two sync stages with margin
  sequence s_clear; !hardware_clear_n [*4]; endsequence
  sequence s_idle; (chip_sel_n && hardware_clear_n) [*5]; endsequence
  property p_saver; power_saver == (!display_on && all_points_on); endproperty
  property p_osc; osc_enable == !power_saver; endproperty
  property p_sup;
    lcd_supply_enable == !power_saver && drivers_grounded == power_saver;
  endproperty
  property p_rev; all_points_on |-> !reverse_polarity; endproperty
  property p_rst;
    $rose(reset_n) |-> !display_on && all_points_on && bias_sel_7 &&
      volume == LCD_VOLUME_RST && start_line == 6'h0;
  endproperty
  property p_clr;
    s_clear |=> volume == LCD_VOLUME_RST && page_addr == 4'h0 &&
      column_addr == 8'h00 && !display_on;
  endproperty
  property p_idle;
    s_idle |=> $stable(column_addr) && $stable(page_addr);
  endproperty
  property p_oe; chip_sel_n [*4] |=> !bus_oe; endproperty
  a_saver: assert property (p_saver) else $error("saver level wrong");
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
  a_sup: assert property (p_sup) else $error("supply or drivers wrong");
  a_rev: assert property (p_rev) else $error("reverse not overridden");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_clr: assert property (p_clr) else $error("clear pin ignored");
  a_idle: assert property (p_idle) else $error("address moved idle");
  a_oe: assert property (p_oe) else $error("bus driven deselected");
endmodule // lcd_command_decoder_asserts
bind lcd_command_decoder lcd_command_decoder_asserts
  lcd_command_decoder_asserts_i (.*);

/* File: testbench/lcd_host_model.sv */
// host model: 8080 parallel writes and msb-first serial bytes
`timescale 1ns/1ns
module lcd_host_model (
  input wire logic clk,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  output logic chip_sel_n,
  output logic cmd_data_select,
  output logic rd_e,
  output logic wr_rw,
  output logic [7:0] bus_in,
  output logic ser_clk,
  output logic ser_data,
  output logic serial_sel,
  output logic mode_6800
);
  initial begin
    chip_sel_n = 1;
    cmd_data_select = 0;
    rd_e = 1;
    wr_rw = 1;
    bus_in = 8'h00;
    ser_clk = 0;
    ser_data = 0;
    serial_sel = 0;
    mode_6800 = 0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic a0, input logic [7:0] d);
    @(negedge clk);
    serial_sel = 0;
    chip_sel_n = 0;
    cmd_data_select = a0;
    bus_in = d;
    wr_rw = 0;
    wait_n(3);
    wr_rw = 1;
    wait_n(3);
    chip_sel_n = 1;
    // a released bus must not keep showing the old byte
    bus_in = ~d;
  endtask
  task automatic ser(input logic [7:0] d);
    @(negedge clk);
    serial_sel = 1;
    chip_sel_n = 0;
    // serial bytes here are commands; a0 may be left high by a data write
    cmd_data_select = 0;
    for (int i = 7; i >= 0; i--) begin
      ser_data = d[i];
      wait_n(3);
      ser_clk = 1;
      wait_n(3);
      ser_clk = 0;
    end
    chip_sel_n = 1;
    ser_data = ~d[0];
  endtask
  // 8080 data read: bus sampled while the read strobe is still low
  task automatic rd(output logic [7:0] d, output logic oe);
    @(negedge clk);
    serial_sel = 0;
    chip_sel_n = 0;
    cmd_data_select = 1;
    rd_e = 0;
    wait_n(6);
    d = bus_out;
    oe = bus_oe;
    rd_e = 1;
    wait_n(3);
    chip_sel_n = 1;
  endtask
  // 6800 write: mode and rw level change only while deselected; the enable pulse comes while selected
  task automatic wr68(input logic a0, input logic [7:0] d);
    @(negedge clk);
    serial_sel = 0;
    mode_6800 = 1;
    rd_e = 0;
    wr_rw = 0;
    wait_n(3);
    chip_sel_n = 0;
    cmd_data_select = a0;
    bus_in = d;
    wait_n(3);
    rd_e = 1;
    wait_n(3);
    rd_e = 0;
    wait_n(3);
    chip_sel_n = 1;
    wait_n(3);
    mode_6800 = 0;
    rd_e = 1;
    wr_rw = 1;
  endtask
endmodule // lcd_host_model

/* File: testbench/lcd_command_decoder_tb.sv */
// testbench: commands through the host model, config outputs compared
`timescale 1ns/1ns
module lcd_command_decoder_tb;
  import lcd_pkg::*;
  logic clk = 0;
  logic reset_n = 0;
  logic hardware_clear_n = 0;
  logic chip_sel_n, cmd_data_select, rd_e, wr_rw, ser_clk, ser_data;
  logic serial_sel, mode_6800, bus_oe, power_saver, osc_enable;
  logic lcd_supply_enable, drivers_grounded, display_on, all_points_on;
  logic reverse_polarity, seg_reverse, com_reverse, bias_sel_7, test_mode;
  logic [7:0] bus_in, bus_out, column_addr;
  logic [5:0] start_line;
  logic [3:0] page_addr;
  logic [2:0] power_control, ratio_select;
  logic [4:0] volume;
  logic [36:0] e, q[$];
  logic [31:0] r;
  logic [7:0] rb;
  logic ro;
  lcd_cfg_s m;
  int fails = 0;
  int cmp_count = 0;
  wire [36:0] obs = {display_on, all_points_on, reverse_polarity,
    seg_reverse, com_reverse, start_line, page_addr, column_addr,
    power_saver, volume, bias_sel_7, power_control, ratio_select, test_mode};
  lcd_command_decoder lcd_command_decoder_i (.*);
  lcd_host_model lcd_host_model_i (.*);
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [36:0] pk(lcd_cfg_s c);
    return {c.disp_on, c.all_on, c.reverse & ~c.all_on, c.seg_rev,
      c.com_rev, c.start_line, c.page, c.col, ~c.disp_on & c.all_on,
      c.volume, c.bias_7, c.power_ctl, c.ratio, c.test_mode};
  endfunction
  task automatic rst_m();
    m = '0;
    m.all_on = 1;
    m.volume = LCD_VOLUME_RST;
    m.bias_7 = 1;
  endtask
  // expectation is noted once the three-edge pipeline has settled
  task automatic note();
    repeat (6) @(negedge clk);
    q.push_back(pk(m));
  endtask
  task automatic send(input logic s, input logic [7:0] d);
    if (s) lcd_host_model_i.ser(d);
    else lcd_host_model_i.wr(1'b0, d);
    note();
  endtask
  task automatic dw(input logic [7:0] d);
    lcd_host_model_i.wr(1'b1, d);
    if (m.col == LCD_COL_LAST) begin
      m.col = 8'h00;
      m.page = (m.page == LCD_PAGE_LAST) ? 4'h0 : m.page + 4'h1;
    end else m.col = m.col + 8'h01;
    note();
  endtask
  task automatic stop_test();
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clk) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      cmp_count++;
      if (obs !== e) begin
        fails++;
        $display("mismatch cfg exp %h got %h", e, obs);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial begin
    void'($urandom(44796));
    r = $urandom;
    rst_m();
    repeat (4) @(negedge clk);
    hardware_clear_n = 1;
    repeat (2) @(negedge clk);
    reset_n = 1;
    note();
    m.disp_on = 1;
    send(0, 8'hAF);
    m.all_on = 0;
    send(0, 8'hA4);
    m.reverse = 1;
    send(0, 8'hA7);
    m.all_on = 1;
    send(0, 8'hA5);
    m.all_on = 0;
    send(0, 8'hA4);
    m.seg_rev = 1;
    lcd_host_model_i.wr68(1'b0, 8'hA1);
    note();
    m.start_line = r[5:0];
    send(0, {LCD_PFX_START, r[5:0]});
    m.volume = r[12:8];
    send(0, {LCD_PFX_VOLUME, r[12:8]});
    m.page = 4'h8;
    send(0, 8'hB8);
    m.col = 8'h80;
    send(0, 8'h18);
    m.col = 8'h83;
    send(0, 8'h03);
    dw(r[23:16]);
    m.page = 4'h2;
    send(0, 8'hB2);
    m.col = 8'h80;
    send(0, 8'h18);
    m.col = 8'h83;
    send(0, 8'h03);
    dw(r[31:24]);
    m.page = 4'h2;
    send(0, 8'hB2);
    m.col = 8'h80;
    send(0, 8'h18);
    m.col = 8'h83;
    send(0, 8'h03);
    lcd_host_model_i.rd(rb, ro);
    cmp_count++;
    if ({ro, rb} !== {1'b1, r[31:24]}) begin
      fails++;
      $display("mismatch read exp %h got %h", {1'b1, r[31:24]}, {ro, rb});
    end
    m.col = 8'h00;
    m.page = 4'h3;
    note();
    m.disp_on = 0;
    send(1, 8'hAE);
    m.all_on = 1;
    send(1, 8'hA5);
    m.disp_on = 1;
    send(0, 8'hAF);
    m.disp_on = 0;
    send(0, 8'hAE);
    m.reverse = 1;
    send(0, 8'hA7);
    rst_m();
    send(0, LCD_CMD_RESET);
    m.seg_rev = 1;
    send(1, 8'hA1);
    hardware_clear_n = 0;
    repeat (4) @(negedge clk);
    hardware_clear_n = 1;
    rst_m();
    note();
    repeat (4) @(negedge clk);
    stop_test();
  end
endmodule // lcd_command_decoder_tb
